//--- srs_regs.svh
// Constants for the supply reset and soft reset block
`ifndef SRS_REGS_SVH
`define SRS_REGS_SVH
`define SRS_CLK_HZ 25000000
`define SRS_EXT_NOM_US 50
`define SRS_EXT_MAX_US 100
`define SRS_EXT_CYCLES ((`SRS_CLK_HZ / 1000000) * `SRS_EXT_NOM_US)
`define SRS_SOFT_RESET_ADDR 7'h00
`define SRS_ADDR_W 7
`define SRS_DATA_W 9
`endif

//--- srs_pkg.sv
// Types for the supply reset and soft reset block
package srs_pkg;
  typedef enum logic [1:0] {
    SRS_ST_HOLD,
    SRS_ST_EXTEND,
    SRS_ST_RUN,
    SRS_ST_SOFT
  } srs_state_t;
endpackage

//--- srs_stretch.sv
// Reset extension counter, restarted whenever supplies are not both valid
`timescale 1ns/1ps
module srs_stretch #(
  parameter int COUNT = 1250
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic supplies_ok,
  output logic done
);
  localparam int CW = $clog2(COUNT + 1);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  wire at_end = (cnt_r == CW'(COUNT));

  assign cnt_nxt = !supplies_ok ? '0 : (at_end ? cnt_r : cnt_r + CW'(1));
  assign done = at_end && supplies_ok;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule

//--- srs_core.sv
// Supply monitored reset, reset extension and software reset
`timescale 1ns/1ps
`include "srs_regs.svh"
// Function
// - No reset pin; supplies and software only
// - Either supply low holds reset
// - Reset forces registers to initial values
// - Host accesses ignored during reset
// - Extend reset 50 us, never over 100
// - Supply dip restarts full extension
// - Write to address zero resets registers
// - First other write ends soft reset
// - Commands via two, three or four wire
module srs_core
  import srs_pkg::*;
#(
  parameter int EXT_CYCLES = `SRS_EXT_CYCLES
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic analog_supply_ok,
  input wire logic core_supply_ok,
  input wire logic [1:0] ctrl_mode,
  input wire logic wr_valid,
  input wire logic rd_valid,
  input wire logic [`SRS_ADDR_W-1:0] wr_addr,
  input wire logic [`SRS_DATA_W-1:0] wr_data,
  output logic por_active,
  output logic regs_clear,
  output logic soft_reset_active,
  output logic wr_accept,
  output logic rd_accept,
  output logic [`SRS_ADDR_W-1:0] acc_addr,
  output logic [`SRS_DATA_W-1:0] acc_data
);
  import srs_pkg::*;

  srs_state_t state_r;
  srs_state_t state_nxt;
  logic por_r;
  logic clr_r;
  logic soft_r;
  logic wr_r;
  logic rd_r;
  logic [`SRS_ADDR_W-1:0] addr_r;
  logic [`SRS_DATA_W-1:0] data_r;
  logic ext_done;

  // Modes 0..2 select two, three or four wire; decode is shared by both strobes
  function automatic logic mode_ok(input logic [1:0] m);
    return m != 2'h3;
  endfunction

  // Only the supply flags can start a power reset; reset_n is the test harness
  // reset of this block, not a device pin
  wire supplies_ok = analog_supply_ok && core_supply_ok;
  wire in_por = (state_r == SRS_ST_HOLD) || (state_r == SRS_ST_EXTEND);
  wire wr_ok = wr_valid && mode_ok(ctrl_mode) && !in_por && supplies_ok;
  wire rd_ok = rd_valid && mode_ok(ctrl_mode) && !in_por && supplies_ok;
  wire wr_zero = wr_ok && (wr_addr == `SRS_SOFT_RESET_ADDR);
  wire wr_other = wr_ok && (wr_addr != `SRS_SOFT_RESET_ADDR);

  srs_stretch #(
    .COUNT(EXT_CYCLES)
  ) u_stretch (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .supplies_ok(supplies_ok),
    .done(ext_done)
  );

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SRS_ST_HOLD: begin
        if (supplies_ok) begin
          state_nxt = SRS_ST_EXTEND;
        end
      end
      SRS_ST_EXTEND: begin
        if (ext_done) begin
          state_nxt = SRS_ST_RUN;
        end
      end
      SRS_ST_RUN: begin
        if (wr_zero) begin
          state_nxt = SRS_ST_SOFT;
        end
      end
      SRS_ST_SOFT: begin
        if (wr_other) begin
          state_nxt = SRS_ST_RUN;
        end
      end
      default: begin
        state_nxt = SRS_ST_HOLD;
      end
    endcase
    if (!supplies_ok) begin
      state_nxt = SRS_ST_HOLD;
    end
  end

  // All outputs registered so every register sees release on one edge
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= SRS_ST_HOLD;
      por_r <= 1'b1;
      clr_r <= 1'b1;
      soft_r <= 1'b0;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      addr_r <= '0;
      data_r <= '0;
    end else begin
      state_r <= state_nxt;
      por_r <= (state_nxt == SRS_ST_HOLD) || (state_nxt == SRS_ST_EXTEND);
      clr_r <= (state_nxt == SRS_ST_HOLD) || (state_nxt == SRS_ST_EXTEND) || wr_zero;
      soft_r <= (state_nxt == SRS_ST_SOFT);
      wr_r <= wr_other;
      rd_r <= rd_ok;
      addr_r <= wr_ok ? wr_addr : addr_r;
      data_r <= wr_ok ? wr_data : data_r;
    end
  end

  assign por_active = por_r;
  assign regs_clear = clr_r;
  assign soft_reset_active = soft_r;
  assign wr_accept = wr_r;
  assign rd_accept = rd_r;
  assign acc_addr = addr_r;
  assign acc_data = data_r;
endmodule

//--- srs_core_properties.sv
// Checker of reset outputs
`timescale 1ns/1ps
module srs_chk(input sys_clk, reset_n, analog_supply_ok, core_supply_ok,
  input por_active, regs_clear, soft_reset_active, wr_accept);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire ok = analog_supply_ok && core_supply_ok;
  wire p = por_active, c = regs_clear, s = soft_reset_active;
  sup_hold_a: assert property (!ok |=> p) else $error("hold");
  init_val_a: assert property (p |-> c) else $error("init");
  no_acc_a: assert property (p |-> !wr_accept) else $error("acc");
  ext_min_a: assert property ($rose(ok) |-> p[*8]) else $error("short");
  ext_max_a: assert property (ok[*8] ##1 ok[*5] |-> !p) else $error("long");
  soft_set_a: assert property ($rose(s) |-> c) else $error("soft");
  soft_end_a: assert property ($fell(s) && !p |-> wr_accept) else $error("end");
  rel_sync_a: assert property ($fell(p) |-> $fell(c)) else $error("sync");
endmodule
bind srs_core srs_chk i_srs_chk(.*);

//--- srs_host_model.sv
// Host model of the control port
`timescale 1ns/1ps
module srs_host_model(input sys_clk, output logic wr_valid, rd_valid,
  output logic [6:0] wr_addr, output logic [8:0] wr_data);
  logic [17:0] bus;
  assign {wr_valid, rd_valid, wr_addr, wr_data} = bus;
  initial bus = '0;
  task automatic xfer(logic w, logic [6:0] a, logic [8:0] d);
    @(negedge sys_clk);
    bus = {w, !w, a, d};
    @(negedge sys_clk);
    // Idle lines invert so a stale word never matches
    bus = {2'b0, ~a, ~d};
  endtask
endmodule

//--- srs_core_tb_top.sv
// Reset block testbench
`timescale 1ns/1ps
module srs_core_tb_top;
  logic sys_clk = 0, reset_n = 0, analog_supply_ok = 0, core_supply_ok = 0, wr_valid, rd_valid;
  logic por_active, regs_clear, soft_reset_active, wr_accept, rd_accept;
  logic [1:0] ctrl_mode = 0;
  logic [6:0] wr_addr, acc_addr;
  logic [8:0] wr_data, acc_data;
  int fails = 0, n_compared = 0;
  wire [4:0] fl = {por_active, regs_clear, soft_reset_active, wr_accept, rd_accept};
  always #20 sys_clk = ~sys_clk;
  srs_host_model i_srs_host_model(.*);
  srs_core #(.EXT_CYCLES(8)) i_srs_core(.*);
  // Sampled at the falling edge right after the launching edge, while pulses stand
  task automatic chk(logic [4:0] e);
    n_compared++;
    if (fl !== e) begin
      fails++;
      $display("unexpected flags %b %b", e, fl);
    end
  endtask
  task automatic chk_acc(logic [6:0] ea, logic [8:0] ed);
    n_compared++;
    if (acc_addr !== ea || acc_data !== ed) begin
      fails++;
      $display("unexpected acc %h %h %h %h", ea, ed, acc_addr, acc_data);
    end
  endtask
  task automatic t_dip;
    core_supply_ok = 0;
    @(negedge sys_clk);
    chk(5'b11000);
    core_supply_ok = 1;
    repeat (4) @(negedge sys_clk);
    core_supply_ok = 0;
    @(negedge sys_clk);
    chk(5'b11000);
    core_supply_ok = 1;
    repeat (8) @(negedge sys_clk);
    chk(5'b11000);
    repeat (2) @(negedge sys_clk);
    chk(5'b00000);
  endtask
  task automatic end_sim;
    $display("fails %0d compared %0d", fails, n_compared);
    if (fails == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic t_pwr;
    i_srs_host_model.xfer(1, 7'h05, 9'h001);
    chk(5'b11000);
    {analog_supply_ok, core_supply_ok} = 2'b11;
    repeat (6) @(negedge sys_clk);
    chk(5'b11000);
    repeat (5) @(negedge sys_clk);
    chk(5'b00000);
  endtask
  task automatic t_soft;
    for (int m = 0; m < 4; m++) begin
      ctrl_mode = 2'(m);
      i_srs_host_model.xfer(1, 7'h00, 9'h1FF);
      chk(m < 3 ? 5'b01100 : 5'b00000);
      i_srs_host_model.xfer(1, 7'h05, 9'h0A5);
      chk(m < 3 ? 5'b00010 : 5'b00000);
    end
  endtask
  initial begin
    repeat (4) @(negedge sys_clk);
    reset_n = 1;
    t_pwr;
    t_soft;
    ctrl_mode = 2'h1;
    i_srs_host_model.xfer(0, 7'h05, 9'h000);
    chk(5'b00001);
    chk_acc(7'h05, 9'h0A5);
    t_dip;
    end_sim;
  end
  initial begin
    #20000;
    fails++;
    end_sim;
  end
endmodule
